// ==== hw/tmr_pkg.sv ====
// Shared constants of the timer/event counter: register map and field codes
package tmr_pkg;
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_PRESC   = 8'h04;
	localparam logic [7:0] OFS_CAPCTL  = 8'h08;
	localparam logic [7:0] OFS_OUTCTL  = 8'h0c;
	localparam logic [7:0] OFS_COUNT   = 8'h10;
	localparam logic [7:0] OFS_CCA     = 8'h14;
	localparam logic [7:0] OFS_CCB     = 8'h18;
	localparam int         MODE_POS    = 2;
	localparam int         TOGSEL_POS  = 1;
	localparam int         CLKSEL_POS  = 0;
	localparam int         EDGEA_POS   = 4;
	localparam int         EDGEB_POS   = 6;
	localparam int         CAPA_POS    = 0;
	localparam int         PHASE_POS   = 1;
	localparam int         CAPB_POS    = 2;
	localparam int         OUTEN_POS   = 0;
	localparam int         OUTMATCH_POS = 1;
	localparam logic [1:0] MODE_STOP   = 2'b00;
	localparam logic [1:0] MODE_FREE   = 2'b01;
	localparam logic [1:0] MODE_EDGECLR = 2'b10;
	localparam logic [1:0] MODE_MATCHCLR = 2'b11;
	localparam logic [1:0] EDGE_FALL   = 2'b00;
	localparam logic [1:0] EDGE_RISE   = 2'b01;
	localparam logic [1:0] EDGE_BOTH   = 2'b11;
	localparam logic [2:0] CLKSEL_EVT  = 3'b110;
	localparam logic [1:0] CLKSEL_EVT_LO = 2'b11;
	localparam logic [2:0] CLKSEL_RST  = 3'b000;
	localparam logic [1:0] EDGE_RST    = 2'b00;
	localparam logic [1:0] MODE_RST    = 2'b00;
	localparam int         SAMPLE_DIV  = 4;
endpackage : tmr_pkg

// ==== hw/edge_if.sv ====
// Interface between the timer core and one input edge filter
`timescale 1ns/10ps
interface edge_if;
	logic       sample_tick;
	logic       raw;
	logic [1:0] sel;
	logic       valid_edge;
	logic       opposite_edge;
	modport filt (input sample_tick, raw, sel, output valid_edge, opposite_edge);
	modport user (output sample_tick, raw, sel, input valid_edge, opposite_edge);
endinterface : edge_if

// ==== hw/edge_filter.sv ====
// Two-sample noise filter and edge selector for one event input
`timescale 1ns/10ps
module edge_filter
	import tmr_pkg::*;
(
	input  wire logic hclk,
	input  wire logic hresetn,
	edge_if.filt      port
);
	logic samp_ff;
	logic level_ff;
	logic valid_ff;
	logic opp_ff;
	logic accept;
	logic rise;
	logic fall;

	// A new level counts only after two equal samples in a row
	assign accept = port.sample_tick && (port.raw == samp_ff) &&
	                (port.raw != level_ff);
	assign rise   = accept && port.raw;
	assign fall   = accept && !port.raw;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_ff  <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			if (port.sample_tick) begin
				samp_ff <= port.raw;
			end
			if (accept) begin
				level_ff <= port.raw;
			end
		end
	end

	// Setting 10 yields no edge at all
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_ff <= 1'b0;
			opp_ff   <= 1'b0;
		end else begin
			case (port.sel)
				EDGE_FALL: begin
					valid_ff <= fall;
					opp_ff   <= rise;
				end
				EDGE_RISE: begin
					valid_ff <= rise;
					opp_ff   <= fall;
				end
				EDGE_BOTH: begin
					valid_ff <= accept;
					opp_ff   <= accept;
				end
				default: begin
					valid_ff <= 1'b0;
					opp_ff   <= 1'b0;
				end
			endcase
		end
	end

	assign port.valid_edge    = valid_ff;
	assign port.opposite_edge = opp_ff;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// A level seen on one sample only must leave the accepted level alone
	a_filter_two_samples: assert property (
		port.sample_tick && (port.raw != samp_ff) |=> $stable(level_ff))
		else $error("edge accepted without two equal samples");
endmodule : edge_filter

// ==== hw/timer_event_counter.sv ====
// Timer/event counter core with AHB-Lite register slave
// What this block does
// - Square wave toggles every M+1 count clocks, frequency 1/(2(M+1)).
// - Compare B match raises interrupt B even if unused; software masks it.
// - Clock select low bits 11 and mode 11 count event A edges.
// - First match after M+2 edges, later ones after M+1 edges.
// - Input A edge valid only after two equal consecutive samples.
// - Edge select: 00 falling, 01 rising, 11 both, 10 prohibited.
// - Mode 00 stops counting and clears the counter.
// - Reading the count register returns the current count.
// - Mode 10 counts up; valid edge A clears; otherwise wraps.
// - Mode 10 counts at once without waiting for an edge.
// - Compare registers in mode 10 raise interrupt A or B on match.
// - Capture A on edge B or opposite edge A; only edge B raises interrupt A.
// - Capture B on edge A raises interrupt B and clears the counter.
// - Toggle select chooses match-only or match plus edge A inversion.
// - Phase select set: opposite edge A capture gives no interrupt A.
// - Mode 11 clears counter on compare A match and raises interrupt A.
// - Output control 03H inverts output on each compare A match.
// - Mode 10 compare matches raise interrupts without clearing.
`timescale 1ns/10ps
module timer_event_counter #(
	parameter int W         = 16,
	parameter int SAMP_DIV  = tmr_pkg::SAMPLE_DIV
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	input  wire logic          event_input_a,
	input  wire logic          event_input_b,
	output logic               timer_output,
	output logic               match_irq_a,
	output logic               match_irq_b
);
	import tmr_pkg::*;

	localparam logic [W-1:0] CNT_ONE  = W'(1);
	localparam logic [W-1:0] CNT_ZERO = '0;

	edge_if ea ();
	edge_if eb ();

	logic [1:0]   mode_ff;
	logic         toggle_sel_ff;
	logic [2:0]   clk_sel_ff;
	logic [1:0]   edge_a_sel_ff;
	logic [1:0]   edge_b_sel_ff;
	logic         cap_a_en_ff;
	logic         phase_sel_ff;
	logic         cap_b_en_ff;
	logic         out_en_ff;
	logic         out_match_ff;
	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;
	logic [W-1:0] cca_ff;
	logic [W-1:0] ccb_ff;
	logic         started_ff;
	logic         timer_output_ff;
	logic         match_irq_a_ff;
	logic         match_irq_b_ff;
	logic [4:0]   div_ff;
	logic [7:0]   samp_div_ff;
	logic         wr_pend_ff;
	logic [7:0]   addr_ff;
	logic [31:0]  hrdata_ff;
	logic [31:0]  rd_mux;
	logic         access;
	logic         event_clk;
	logic         tick;
	logic         running;
	logic         edge_mode;
	logic         adv;
	logic         first;
	logic         cmp_a;
	logic         cmp_b;
	logic         clear_edge;
	logic         cap_a_trig;
	logic         irq_a_cap;
	logic         cap_b_trig;
	logic         tog;
	logic         rd_count;

	function automatic logic [4:0] tick_mask(input logic [2:0] sel);
		logic [4:0] m;
		m = 5'h00;
		if (sel < 3'h6) begin
			m = 5'((6'h01 << sel) - 6'h01);
		end
		return m;
	endfunction : tick_mask

	// Input sampling clock as a strobe; both filters share it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_div_ff <= 8'h00;
		end else if (samp_div_ff == 8'(SAMP_DIV - 1)) begin
			samp_div_ff <= 8'h00;
		end else begin
			samp_div_ff <= samp_div_ff + 8'h01;
		end
	end

	assign ea.sample_tick = (samp_div_ff == 8'(SAMP_DIV - 1));
	assign ea.raw         = event_input_a;
	assign ea.sel         = edge_a_sel_ff;
	assign eb.sample_tick = (samp_div_ff == 8'(SAMP_DIV - 1));
	assign eb.raw         = event_input_b;
	assign eb.sel         = edge_b_sel_ff;

	edge_filter u_filt_a (
		.hclk    (hclk),
		.hresetn (hresetn),
		.port    (ea.filt)
	);

	edge_filter u_filt_b (
		.hclk    (hclk),
		.hresetn (hresetn),
		.port    (eb.filt)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff <= 5'h00;
		end else begin
			div_ff <= div_ff + 5'h01;
		end
	end

	assign event_clk  = (clk_sel_ff[1:0] == CLKSEL_EVT_LO) ||
	                    (clk_sel_ff == CLKSEL_EVT);
	assign tick       = event_clk ? ea.valid_edge :
	                    ((div_ff & tick_mask(clk_sel_ff)) ==
	                     tick_mask(clk_sel_ff));
	assign running    = (mode_ff != MODE_STOP);
	assign edge_mode  = (mode_ff == MODE_EDGECLR);
	assign adv        = running && tick;
	// The start edge only arms the counter, hence the extra edge first time
	assign first      = (mode_ff == MODE_MATCHCLR) && !started_ff;
	assign cmp_a      = adv && !first && !(edge_mode && cap_a_en_ff) &&
	                    (count_ff == cca_ff);
	assign cmp_b      = adv && !first && !(edge_mode && cap_b_en_ff) &&
	                    (count_ff == ccb_ff);
	assign clear_edge = edge_mode && ea.valid_edge;
	assign cap_a_trig = edge_mode && cap_a_en_ff &&
	                    (phase_sel_ff ? ea.opposite_edge : eb.valid_edge);
	assign irq_a_cap  = edge_mode && cap_a_en_ff && eb.valid_edge;
	assign cap_b_trig = edge_mode && cap_b_en_ff && ea.valid_edge;

	always_comb begin
		nxt_count = count_ff;
		if (!running) begin
			nxt_count = CNT_ZERO;
		end else if (clear_edge) begin
			nxt_count = CNT_ZERO;
		end else if (adv) begin
			if (first) begin
				nxt_count = CNT_ZERO;
			end else if (cmp_a && mode_ff == MODE_MATCHCLR) begin
				nxt_count = CNT_ZERO;
			end else begin
				nxt_count = count_ff + CNT_ONE;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff   <= CNT_ZERO;
			started_ff <= 1'b0;
		end else begin
			count_ff   <= nxt_count;
			started_ff <= running && (started_ff || adv);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_irq_a_ff <= 1'b0;
			match_irq_b_ff <= 1'b0;
		end else begin
			match_irq_a_ff <= cmp_a || irq_a_cap;
			match_irq_b_ff <= cmp_b || cap_b_trig;
		end
	end

	// Compare B only steers the output outside the match-clear mode
	assign tog = (out_match_ff && (cmp_a ||
	              (cmp_b && mode_ff != MODE_MATCHCLR))) ||
	             (clear_edge && toggle_sel_ff);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_output_ff <= 1'b0;
		end else if (!out_en_ff) begin
			timer_output_ff <= 1'b0;
		end else if (tog) begin
			timer_output_ff <= !timer_output_ff;
		end
	end

	// Bus slave: no wait states, so the address phase is always accepted
	assign access   = hsel && htrans[1] && hready;
	assign rd_count = access && !hwrite && (haddr[7:0] == OFS_COUNT);

	always_comb begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			OFS_MODE: begin
				rd_mux[MODE_POS +: 2] = mode_ff;
				rd_mux[TOGSEL_POS]    = toggle_sel_ff;
			end
			OFS_PRESC: begin
				rd_mux[CLKSEL_POS +: 3] = clk_sel_ff;
				rd_mux[EDGEA_POS +: 2]  = edge_a_sel_ff;
				rd_mux[EDGEB_POS +: 2]  = edge_b_sel_ff;
			end
			OFS_CAPCTL: begin
				rd_mux[CAPA_POS]  = cap_a_en_ff;
				rd_mux[PHASE_POS] = phase_sel_ff;
				rd_mux[CAPB_POS]  = cap_b_en_ff;
			end
			OFS_OUTCTL: begin
				rd_mux[OUTEN_POS]    = out_en_ff;
				rd_mux[OUTMATCH_POS] = out_match_ff;
			end
			OFS_COUNT: rd_mux[W-1:0] = count_ff;
			OFS_CCA:   rd_mux[W-1:0] = cca_ff;
			OFS_CCB:   rd_mux[W-1:0] = ccb_ff;
			default:   rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
			hrdata_ff  <= 32'h00000000;
		end else begin
			wr_pend_ff <= access && hwrite;
			addr_ff    <= haddr[7:0];
			if (access && !hwrite) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ff       <= MODE_RST;
			toggle_sel_ff <= 1'b0;
			clk_sel_ff    <= CLKSEL_RST;
			edge_a_sel_ff <= EDGE_RST;
			edge_b_sel_ff <= EDGE_RST;
			cap_a_en_ff   <= 1'b0;
			phase_sel_ff  <= 1'b0;
			cap_b_en_ff   <= 1'b0;
			out_en_ff     <= 1'b0;
			out_match_ff  <= 1'b0;
		end else if (wr_pend_ff) begin
			case (addr_ff)
				OFS_MODE: begin
					mode_ff       <= hwdata[MODE_POS +: 2];
					toggle_sel_ff <= hwdata[TOGSEL_POS];
				end
				OFS_PRESC: begin
					clk_sel_ff    <= hwdata[CLKSEL_POS +: 3];
					edge_a_sel_ff <= hwdata[EDGEA_POS +: 2];
					edge_b_sel_ff <= hwdata[EDGEB_POS +: 2];
				end
				OFS_CAPCTL: begin
					cap_a_en_ff  <= hwdata[CAPA_POS];
					phase_sel_ff <= hwdata[PHASE_POS];
					cap_b_en_ff  <= hwdata[CAPB_POS];
				end
				OFS_OUTCTL: begin
					out_en_ff    <= hwdata[OUTEN_POS];
					out_match_ff <= hwdata[OUTMATCH_POS];
				end
				default: begin
				end
			endcase
		end
	end

	// A capture beats a software write landing in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cca_ff <= CNT_ZERO;
			ccb_ff <= CNT_ZERO;
		end else begin
			if (cap_a_trig) begin
				cca_ff <= count_ff;
			end else if (wr_pend_ff && addr_ff == OFS_CCA) begin
				cca_ff <= hwdata[W-1:0];
			end
			if (cap_b_trig) begin
				ccb_ff <= count_ff;
			end else if (wr_pend_ff && addr_ff == OFS_CCB) begin
				ccb_ff <= hwdata[W-1:0];
			end
		end
	end

	assign hrdata       = hrdata_ff;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign timer_output = timer_output_ff;
	assign match_irq_a  = match_irq_a_ff;
	assign match_irq_b  = match_irq_b_ff;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_stop_clears_count: assert property (
		mode_ff == MODE_STOP |=> count_ff == CNT_ZERO)
		else $error("stopped counter not zero");
	a_match_clear_irq: assert property (
		cmp_a && mode_ff == MODE_MATCHCLR |=> count_ff == CNT_ZERO &&
		match_irq_a_ff)
		else $error("match clear missing");
	a_first_edge_arms: assert property (
		first && adv |=> started_ff && count_ff == CNT_ZERO)
		else $error("first edge not absorbed");
	a_event_hold: assert property (
		mode_ff == MODE_MATCHCLR && event_clk && !ea.valid_edge
		|=> $stable(count_ff))
		else $error("event counter moved without an edge");
	a_edge_clear_count: assert property (
		clear_edge |=> count_ff == CNT_ZERO)
		else $error("edge clear missing");
	a_edge_mode_runs: assert property (
		edge_mode && adv && !clear_edge
		|=> count_ff == $past(count_ff) + CNT_ONE)
		else $error("edge mode count did not advance");
	a_capture_b_value: assert property (
		cap_b_trig |=> ccb_ff == $past(count_ff) && match_irq_b_ff &&
		count_ff == CNT_ZERO)
		else $error("capture B wrong");
	a_capture_a_value: assert property (
		cap_a_trig |=> cca_ff == $past(count_ff))
		else $error("capture A wrong");
	a_phase_no_irq: assert property (
		edge_mode && cap_a_en_ff && phase_sel_ff && !eb.valid_edge
		|=> !match_irq_a_ff)
		else $error("phase capture raised interrupt A");
	a_cmp_b_irq: assert property (
		cmp_b |=> match_irq_b_ff)
		else $error("compare B interrupt missing");
	a_output_idle: assert property (
		!out_en_ff |=> !timer_output_ff)
		else $error("disabled output moved");
	a_output_toggle: assert property (
		out_en_ff && tog |=> timer_output_ff != $past(timer_output_ff))
		else $error("output did not invert");
	a_count_read: assert property (
		rd_count |=> hrdata_ff[W-1:0] == $past(count_ff))
		else $error("count read wrong");

	c_match_clear: cover property (cmp_a && mode_ff == MODE_MATCHCLR);
	c_capture_b:   cover property (cap_b_trig);
	c_phase_cap:   cover property (cap_a_trig && phase_sel_ff);
	c_toggle:      cover property (out_en_ff && tog);
endmodule : timer_event_counter

// ==== verification/event_source.sv ====
// Behavioural model of the two external event and trigger sources
`timescale 1ns/10ps
module event_source (
	input  wire logic hclk,
	output logic      ev_a,
	output logic      ev_b
);
	initial begin
		ev_a = 1'b0;
		ev_b = 1'b0;
	end
	// Level is held long enough for the two-sample filter to accept it
	task automatic drive(input bit b, input logic l, input int hold);
		@(posedge hclk);
		if (b)
			ev_b <= l;
		else
			ev_a <= l;
		repeat (hold) @(posedge hclk);
	endtask : drive
	// One-cycle spike, shorter than two sample periods, so it must vanish
	task automatic glitch();
		@(posedge hclk);
		ev_a <= ~ev_a;
		@(posedge hclk);
		ev_a <= ~ev_a;
	endtask : glitch
endmodule : event_source

// ==== verification/timer_event_counter_modes_test.sv ====
// Self-checking bench of the timer/event counter over AHB-Lite
`timescale 1ns/10ps
`define check(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
	error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, (got), \
	(exp)); end end
module timer_event_counter_modes_test
	import tmr_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         ev_a;
	wire         ev_b;
	wire         timer_output;
	wire         match_irq_a;
	wire         match_irq_b;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          na = 0;
	int          nb = 0;

	timer_event_counter #(.SAMP_DIV(2)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .event_input_a(ev_a), .event_input_b(ev_b),
		.timer_output(timer_output), .match_irq_a(match_irq_a),
		.match_irq_b(match_irq_b)
	);
	event_source src (.hclk(hclk), .ev_a(ev_a), .ev_b(ev_b));

	always #2 hclk = ~hclk;
	always @(posedge hclk) begin
		if (match_irq_a === 1'b1)
			na <= na + 1;
		if (match_irq_b === 1'b1)
			nb <= nb + 1;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// The master waits on hready, never on an assumed latency
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask : rd

	function automatic logic sig(input int w);
		case (w)
			0: return match_irq_a;
			1: return match_irq_b;
			default: return timer_output;
		endcase
	endfunction : sig
	// Cycles between two events: irq pulses, or output changes for w=2
	task automatic gap(input int w, output int c);
		logic p;
		bit   f;
		f = 0;
		c = 0;
		p = sig(w);
		repeat (200) begin
			@(posedge hclk);
			#1;
			c++;
			if (w == 2 ? sig(w) !== p : sig(w) === 1'b1) begin
				if (f)
					break;
				f = 1;
				c = 0;
			end
			p = sig(w);
		end
	endtask : gap

	task automatic edge_a(input logic [1:0] s);
		logic l;
		// Target level taken before the spike, whose restore is still pending
		l = ~ev_a;
		src.glitch();
		case (s)
			EDGE_FALL: begin
				src.drive(0, 1'b1, 30);
				src.drive(0, 1'b0, 30);
			end
			EDGE_BOTH: src.drive(0, l, 12);
			default: begin
				src.drive(0, 1'b0, 12);
				src.drive(0, 1'b1, 12);
			end
		endcase
		#1;
	endtask : edge_a

	task automatic t_reset();
		logic [31:0] q;
		for (int a = 0; a < 32; a += 4) begin
			rd(a[7:0], q);
			`check(q, 32'h0)
		end
		wr(OFS_COUNT, 32'h55);
		rd(OFS_COUNT, q);
		`check(q, 32'h0)
		$display("test reset done");
	endtask : t_reset

	task automatic t_interval();
		int          c;
		logic [31:0] q;
		logic        o;
		wr(OFS_CCA, 32'h5);
		wr(OFS_CCB, 32'h2);
		wr(OFS_PRESC, 32'h0);
		wr(OFS_OUTCTL, 32'h3);
		wr(OFS_MODE, 32'hc);
		gap(0, c);
		`check(c, 6)
		gap(2, c);
		`check(c, 6)
		gap(1, c);
		`check(c, 6)
		rd(OFS_COUNT, q);
		`check(q <= 32'h5, 1'b1)
		wr(OFS_OUTCTL, 32'h0);
		o = 1'b0;
		repeat (2) @(posedge hclk);
		repeat (20) begin
			@(posedge hclk);
			o = o | timer_output;
		end
		`check(o, 1'b0)
		wr(OFS_MODE, 32'h0);
		rd(OFS_COUNT, q);
		`check(q, 32'h0)
		repeat (10) @(posedge hclk);
		rd(OFS_COUNT, q);
		`check(q, 32'h0)
		$display("test interval done");
	endtask : t_interval

	task automatic t_events();
		logic [1:0]  sel;
		logic [31:0] q;
		int          n0;
		int          e;
		for (int s = 0; s < 4; s++) begin
			sel = s[1:0];
			wr(OFS_MODE, 32'h0);
			wr(OFS_CCA, 32'h3);
			wr(OFS_PRESC, {26'h0, sel, 4'h3});
			wr(OFS_MODE, 32'hc);
			n0 = na;
			for (int k = 1; k <= 10; k++) begin
				edge_a(sel);
				e = (sel == 2'b10) ? 0 : (k >= 9) ? 2 : (k >= 5) ? 1 : 0;
				`check(na - n0, e)
			end
			rd(OFS_COUNT, q);
			if (sel == 2'b10)
				`check(q, 32'h0)
			else
				`check(q, 32'h1)
		end
		$display("test events done");
	endtask : t_events

	task automatic t_edgeclr();
		logic [31:0] q;
		logic [31:0] c1;
		logic        t;
		int          b0;
		int          a0;
		src.drive(0, 1'b0, 12);
		wr(OFS_MODE, 32'h0);
		wr(OFS_CCA, 32'd20);
		wr(OFS_PRESC, 32'h10);
		wr(OFS_CAPCTL, 32'h4);
		wr(OFS_OUTCTL, 32'h3);
		a0 = na;
		wr(OFS_MODE, 32'ha);
		repeat (40) @(posedge hclk);
		#1;
		`check(na - a0, 1)
		rd(OFS_COUNT, c1);
		`check(c1 > 32'd20, 1'b1)
		b0 = nb;
		t = timer_output;
		src.drive(0, 1'b1, 12);
		#1;
		`check(nb - b0, 1)
		`check(timer_output, ~t)
		rd(OFS_CCB, q);
		`check(q > c1, 1'b1)
		rd(OFS_COUNT, q);
		`check(q < 32'd20, 1'b1)
		wr(OFS_MODE, 32'h8);
		src.drive(0, 1'b0, 12);
		#1;
		t = timer_output;
		src.drive(0, 1'b1, 12);
		#1;
		`check(timer_output, t)
		$display("test edge clear done");
	endtask : t_edgeclr

	task automatic t_capture();
		logic [31:0] q;
		int          a0;
		wr(OFS_CCA, 32'hffff);
		wr(OFS_PRESC, 32'h50);
		wr(OFS_CAPCTL, 32'h1);
		src.drive(1, 1'b0, 12);
		a0 = na;
		src.drive(1, 1'b1, 12);
		#1;
		`check(na - a0, 1)
		rd(OFS_CCA, q);
		`check(q < 32'hffff, 1'b1)
		wr(OFS_CCA, 32'hffff);
		wr(OFS_CAPCTL, 32'h3);
		a0 = na;
		src.drive(0, 1'b0, 12);
		#1;
		`check(na - a0, 0)
		rd(OFS_CCA, q);
		`check(q < 32'hffff, 1'b1)
		wr(OFS_CCA, 32'hffff);
		src.drive(1, 1'b0, 12);
		a0 = na;
		src.drive(1, 1'b1, 12);
		#1;
		`check(na - a0, 1)
		rd(OFS_CCA, q);
		`check(q, 32'hffff)
		$display("test capture done");
	endtask : t_capture

	// Whole run needs under two thousand cycles; this cuts a hang short
	initial begin
		repeat (30000) @(posedge hclk);
		error_cnt++;
		results();
	end

	initial begin
		hclk    = 1'b0;
		hresetn = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'b00;
		hwrite  = 1'b0;
		hsize   = 3'b010;
		hwdata  = 32'h0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_interval();
		t_events();
		t_edgeclr();
		t_capture();
		results();
	end
endmodule : timer_event_counter_modes_test
